// ==== logic/ldw_top.sv ====
// eight-digit LED driver: host write port, display memory, decoders and drive
//
// Operation
// - Input lines are captured into control or display memory on the write strobe's rising edge.
// - Register select high writes the control register, low writes the display memory.
// - Display writes take lines 0..7 as data bits 1..8, bit 8 lighting the decimal point.
// - Control line 6 high selects hexadecimal characters, low selects the Code B set.
// - Control line 5 high bypasses character lookup so data bits drive segments directly.
// - Control line 7 high announces a full sequential update, low a single-digit update.
// - Control line 4 low stops the scan and blanks the display, high runs normally.
// - With line 7 low, control lines 2..0 are latched as the digit address, line 2 the MSB.
// - Control line 3 picks bank A when high and bank B when low, only while decoding.
// - The eight digits are multiplexed so that each is refreshed at about 390 Hz.
// - At least 2 us of blanking separates one digit drive from the next.
// - Eight digit drive outputs and eight segment outputs (a..g and point) are provided.
`timescale 1ns/10ps
module ldw_top #(
  parameter logic [ldw_pkg::CNT_W-1:0] P_SLOT_CYC = ldw_pkg::CNT_W'(ldw_pkg::SLOT_CYC),
  parameter logic [ldw_pkg::CNT_W-1:0] P_BLANK_CYC = ldw_pkg::CNT_W'(ldw_pkg::BLANK_CYC)
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ldw_pkg::DATA_W-1:0] i_input_line,
  input wire logic i_reg_select,
  input wire logic i_write_strobe,
  output logic [ldw_pkg::DIGITS-1:0] o_digit_drive,
  output logic [ldw_pkg::SEG_W-1:0] o_segment_out
);
  import ldw_pkg::*;

  // hexadecimal glyphs, segment order {g,f,e,d,c,b,a}
  function automatic logic [6:0] hex_glyph(input logic [3:0] nib);
    logic [6:0] g;
    g = 7'h00;
    case (nib)
      4'h0: g = 7'h3F;
      4'h1: g = 7'h06;
      4'h2: g = 7'h5B;
      4'h3: g = 7'h4F;
      4'h4: g = 7'h66;
      4'h5: g = 7'h6D;
      4'h6: g = 7'h7D;
      4'h7: g = 7'h07;
      4'h8: g = 7'h7F;
      4'h9: g = 7'h6F;
      4'hA: g = 7'h77;
      4'hB: g = 7'h7C;
      4'hC: g = 7'h39;
      4'hD: g = 7'h5E;
      4'hE: g = 7'h79;
      4'hF: g = 7'h71;
      default: g = 7'h00;
    endcase
    return g;
  endfunction : hex_glyph

  // Code B glyphs: digits, dash, E, H, L, P, blank
  function automatic logic [6:0] codeb_glyph(input logic [3:0] nib);
    logic [6:0] g;
    g = 7'h00;
    case (nib)
      4'hA: g = 7'h40;
      4'hB: g = 7'h79;
      4'hC: g = 7'h76;
      4'hD: g = 7'h38;
      4'hE: g = 7'h73;
      4'hF: g = 7'h00;
      default: g = hex_glyph(nib);
    endcase
    return g;
  endfunction : codeb_glyph

  // segment pattern {point,g,f,e,d,c,b,a} for one stored byte
  function automatic logic [SEG_W-1:0] seg_of(input logic [DATA_W-1:0] dat,
                                               input logic [DATA_W-1:0] ctl);
    logic [SEG_W-1:0] s;
    s = '0;
    if (ctl[CTL_NO_DECODE]) begin
      s = dat;
    end else if (ctl[CTL_HEX]) begin
      s = {dat[DAT_POINT], hex_glyph(dat[3:0])};
    end else begin
      s = {dat[DAT_POINT], codeb_glyph(dat[3:0])};
    end
    return s;
  endfunction : seg_of

  // pin synchroniser: three stages, a change is taken once stages two and three agree
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_filt_reg;
  logic [PIN_W-1:0] pin_filt_next;
  logic strobe_prev_reg;
  logic wr_rise;

  always_comb begin
    pin_filt_next = ((pin_s2_reg ~^ pin_s3_reg) & pin_s2_reg) |
                    ((pin_s2_reg ^ pin_s3_reg) & pin_filt_reg);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_filt_reg <= '0;
      strobe_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {i_write_strobe, i_reg_select, i_input_line};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_filt_reg <= pin_filt_next;
      strobe_prev_reg <= pin_filt_reg[PIN_STROBE];
    end
  end

  assign wr_rise = pin_filt_reg[PIN_STROBE] && !strobe_prev_reg;

  // write port state: control register, entry mode, digit pointer, two banks
  logic [DATA_W-1:0] ctl_reg;
  logic [DATA_W-1:0] ctl_next;
  ldw_entry_e entry_reg;
  ldw_entry_e entry_next;
  logic [DIG_AW-1:0] ptr_reg;
  logic [DIG_AW-1:0] ptr_next;
  logic [DATA_W-1:0] bank_a_reg [DIGITS];
  logic [DATA_W-1:0] bank_a_next [DIGITS];
  logic [DATA_W-1:0] bank_b_reg [DIGITS];
  logic [DATA_W-1:0] bank_b_next [DIGITS];
  logic [DATA_W-1:0] wr_data;
  logic use_bank_a;
  logic ram_we;

  assign wr_data = pin_filt_reg[DATA_W-1:0];
  assign use_bank_a = ctl_reg[CTL_BANK_A] || ctl_reg[CTL_NO_DECODE];

  always_comb begin
    ctl_next = ctl_reg;
    entry_next = entry_reg;
    ptr_next = ptr_reg;
    bank_a_next = bank_a_reg;
    bank_b_next = bank_b_reg;
    ram_we = 1'b0;
    if (wr_rise && pin_filt_reg[PIN_SELECT]) begin
      ctl_next = wr_data;
      if (wr_data[CTL_DATA_COMING]) begin
        entry_next = LDW_SEQ;
        ptr_next = '0;
      end else begin
        entry_next = LDW_SINGLE;
        ptr_next = wr_data[CTL_ADDR_HI:CTL_ADDR_LO];
      end
    end else if (wr_rise) begin
      case (entry_reg)
        LDW_SEQ: begin
          ram_we = 1'b1;
          ptr_next = ptr_reg + 1'b1;
          if (ptr_reg == DIG_AW'(DIGITS - 1)) begin
            entry_next = LDW_IDLE;
          end
        end
        LDW_SINGLE: begin
          ram_we = 1'b1;
          entry_next = LDW_IDLE;
        end
        LDW_IDLE: begin
          ram_we = 1'b0;
        end
        default: begin
          entry_next = LDW_IDLE;
        end
      endcase
    end
    if (ram_we) begin
      if (use_bank_a) begin
        bank_a_next[ptr_reg] = wr_data;
      end else begin
        bank_b_next[ptr_reg] = wr_data;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctl_reg <= CTL_RESET;
      entry_reg <= LDW_IDLE;
      ptr_reg <= '0;
      for (int i = 0; i < DIGITS; i++) begin
        bank_a_reg[i] <= RAM_RESET;
        bank_b_reg[i] <= RAM_RESET;
      end
    end else begin
      ctl_reg <= ctl_next;
      entry_reg <= entry_next;
      ptr_reg <= ptr_next;
      bank_a_reg <= bank_a_next;
      bank_b_reg <= bank_b_next;
    end
  end

  // digit scanner
  ldw_scan_if sif ();

  assign sif.run = ctl_reg[CTL_RUN];

  ldw_scan #(
    .P_SLOT_CYC(P_SLOT_CYC),
    .P_BLANK_CYC(P_BLANK_CYC)
  ) u_scan (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .sif(sif)
  );

  // drive outputs, registered
  logic [DIGITS-1:0] digit_reg;
  logic [DIGITS-1:0] digit_next;
  logic [SEG_W-1:0] seg_reg;
  logic [SEG_W-1:0] seg_next;
  logic [DATA_W-1:0] shown;

  always_comb begin
    digit_next = '0;
    seg_next = '0;
    shown = use_bank_a ? bank_a_reg[sif.digit] : bank_b_reg[sif.digit];
    if (sif.lit && ctl_reg[CTL_RUN]) begin
      digit_next[sif.digit] = 1'b1;
      seg_next = seg_of(shown, ctl_reg);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      digit_reg <= '0;
      seg_reg <= '0;
    end else begin
      digit_reg <= digit_next;
      seg_reg <= seg_next;
    end
  end

  assign o_digit_drive = digit_reg;
  assign o_segment_out = seg_reg;
endmodule : ldw_top

// ==== logic/ldw_pkg.sv ====
// constants and types shared by the display write port and the digit scanner
package ldw_pkg;
  // pin group widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIGITS = 8;
  localparam int unsigned DIG_AW = 3;
  localparam int unsigned SEG_W = 8;
  localparam int unsigned PIN_W = DATA_W + 2;

  // position of the strobe and the select inside the synchronised pin vector
  localparam int unsigned PIN_STROBE = 9;
  localparam int unsigned PIN_SELECT = 8;

  // display_control field positions
  localparam int unsigned CTL_DATA_COMING = 7;
  localparam int unsigned CTL_HEX = 6;
  localparam int unsigned CTL_NO_DECODE = 5;
  localparam int unsigned CTL_RUN = 4;
  localparam int unsigned CTL_BANK_A = 3;
  localparam int unsigned CTL_ADDR_HI = 2;
  localparam int unsigned CTL_ADDR_LO = 0;

  // display data field positions
  localparam int unsigned DAT_POINT = 7;
  localparam int unsigned SEG_POINT = 7;

  // reset values: running, code B, decoded, bank B, no data coming
  localparam logic [7:0] CTL_RESET = 8'h10;
  localparam logic [7:0] RAM_RESET = 8'h00;

  // timing
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam longint unsigned SCAN_RATE_HZ = 390;
  localparam longint unsigned BLANK_NS = 2000;
  localparam longint unsigned SLOT_CYC = CLK_HZ / (SCAN_RATE_HZ * DIGITS);
  localparam longint unsigned BLANK_CYC = (BLANK_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0] {LDW_IDLE, LDW_SEQ, LDW_SINGLE} ldw_entry_e;
endpackage : ldw_pkg

// ==== logic/ldw_scan_if.sv ====
// carrier between the write port and the digit scanner
`timescale 1ns/10ps
interface ldw_scan_if;
  import ldw_pkg::*;
  logic run;
  logic [DIG_AW-1:0] digit;
  logic lit;
  modport ctl (output run, input digit, input lit);
  modport scan (input run, output digit, output lit);
endinterface : ldw_scan_if

// ==== logic/ldw_scan.sv ====
// digit scanner: slot timing, blanking and digit index
`timescale 1ns/10ps
module ldw_scan #(
  parameter logic [ldw_pkg::CNT_W-1:0] P_SLOT_CYC = ldw_pkg::CNT_W'(ldw_pkg::SLOT_CYC),
  parameter logic [ldw_pkg::CNT_W-1:0] P_BLANK_CYC = ldw_pkg::CNT_W'(ldw_pkg::BLANK_CYC)
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  ldw_scan_if.scan sif
);
  import ldw_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [DIG_AW-1:0] digit_reg;
  logic [DIG_AW-1:0] digit_next;
  logic lit_reg;
  logic lit_next;

  always_comb begin
    cnt_next = '0;
    digit_next = digit_reg;
    if (!sif.run) begin
      // oscillator stopped: scan parks on the first digit
      digit_next = '0;
    end else if (cnt_reg == P_SLOT_CYC - 1'b1) begin
      digit_next = digit_reg + 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
    lit_next = sif.run && (cnt_next >= P_BLANK_CYC);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
      digit_reg <= '0;
      lit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      digit_reg <= digit_next;
      lit_reg <= lit_next;
    end
  end

  assign sif.digit = digit_reg;
  assign sif.lit = lit_reg;
endmodule : ldw_scan

// ==== sim/ldw_top_properties.sv ====
// pin-level assertions for the display driver
`timescale 1ns/10ps
module ldw_top_properties #(
  parameter logic [ldw_pkg::CNT_W-1:0] P_SLOT_CYC = 16'd40,
  parameter logic [ldw_pkg::CNT_W-1:0] P_BLANK_CYC = 16'd5
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ldw_pkg::DATA_W-1:0] i_input_line,
  input wire logic i_reg_select,
  input wire logic i_write_strobe,
  input wire logic [ldw_pkg::DIGITS-1:0] o_digit_drive,
  input wire logic [ldw_pkg::SEG_W-1:0] o_segment_out
);
  import ldw_pkg::*;
  logic lit;
  logic [CNT_W-1:0] gap_reg, gap_next, lit_reg, lit_next;
  assign lit = |o_digit_drive;
  always_comb begin
    gap_next = (lit || gap_reg == '1) ? (lit ? '0 : gap_reg) : gap_reg + 1'b1;
    lit_next = (!lit || lit_reg == '1) ? (lit ? lit_reg : '0) : lit_reg + 1'b1;
  end
  always_ff @(posedge i_ref_clk) begin
    gap_reg <= i_rstn ? gap_next : '0;
    lit_reg <= i_rstn ? lit_next : '0;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence shut_wr;
    i_reg_select && !i_input_line[CTL_RUN] && $rose(i_write_strobe);
  endsequence
  sequence lit_start;
    $rose(lit);
  endsequence
  one_hot_digit_a: assert property ($onehot0(o_digit_drive))
    else $error("more than one digit driven");
  dark_segments_a: assert property (!lit |-> o_segment_out == '0)
    else $error("segments lit while no digit driven");
  zero_between_a: assert property (lit && $changed(o_digit_drive) |-> !$past(lit))
    else $error("digit drives overlap");
  blank_gap_a: assert property (lit_start |-> gap_reg >= P_BLANK_CYC)
    else $error("blanking gap too short");
  lit_max_a: assert property (lit_reg <= P_SLOT_CYC - P_BLANK_CYC)
    else $error("digit lit longer than its slot");
  shut_dark_a: assert property (shut_wr |-> ##[1:12] !lit)
    else $error("display not blanked after shutdown");
  shut_stays_a: assert property (shut_wr |-> ##10 (!lit)[*8])
    else $error("display lit during shutdown");
  reset_blank_a: assert property ($rose(i_rstn) |-> (!lit)[*4])
    else $error("slot after reset not blank");
endmodule : ldw_top_properties
bind ldw_top ldw_top_properties #(.P_SLOT_CYC(P_SLOT_CYC), .P_BLANK_CYC(P_BLANK_CYC)) u_props (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_input_line(i_input_line),
  .i_reg_select(i_reg_select), .i_write_strobe(i_write_strobe),
  .o_digit_drive(o_digit_drive), .o_segment_out(o_segment_out));

// ==== sim/ldw_host_model.sv ====
// host processor model driving the parallel write pins
`timescale 1ns/10ps
module ldw_host_model (
  input wire logic i_ref_clk,
  output logic [ldw_pkg::DATA_W-1:0] o_input_line,
  output logic o_reg_select,
  output logic o_write_strobe
);
  import ldw_pkg::*;
  initial begin
    o_input_line = '0;
    o_reg_select = 1'b0;
    o_write_strobe = 1'b0;
  end
  // select and data set up before the strobe
  task automatic wr(input logic sel, input logic [DATA_W-1:0] d, input int slow);
    @(posedge i_ref_clk);
    #1;
    o_reg_select = sel;
    o_input_line = d;
    repeat (5 + slow) @(posedge i_ref_clk);
    #1 o_write_strobe = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1 o_write_strobe = 1'b0;
    // zero hold: lines stop showing the value
    o_input_line = ~d;
    o_reg_select = ~sel;
    repeat (4) @(posedge i_ref_clk);
  endtask : wr
endmodule : ldw_host_model

// ==== sim/led_display_host_write_port_bench.sv ====
// self-checking bench for the display driver write port
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module led_display_host_write_port_bench;
  import ldw_pkg::*;
  logic i_ref_clk, i_rstn, sel, strobe;
  logic [7:0] line, dig, seg, v;
  logic [7:0] keep [DIGITS];
  logic [7:0] mem [DIGITS];
  int miscompares, n_checks, ptr, left, seed;
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  ldw_host_model u_host (.i_ref_clk(i_ref_clk), .o_input_line(line), .o_reg_select(sel),
    .o_write_strobe(strobe));
  ldw_top #(.P_SLOT_CYC(16'd40), .P_BLANK_CYC(16'd5)) u_dut (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_input_line(line), .i_reg_select(sel), .i_write_strobe(strobe),
    .o_digit_drive(dig), .o_segment_out(seg));
  function automatic logic [7:0] exp_drive(input int d);
    return 8'h01 << d;
  endfunction : exp_drive
  // entry pointer of the expected memory
  task automatic ctl_wr(input logic [7:0] v);
    u_host.wr(1'b1, v, $urandom_range(0, 3));
    ptr = v[7] ? 0 : int'(v[2:0]);
    left = v[7] ? 8 : 1;
  endtask : ctl_wr
  task automatic dat_wr(input logic [7:0] v);
    u_host.wr(1'b0, v, 0);
    if (left > 0) begin
      mem[ptr] = v;
      ptr++;
      left--;
    end
  endtask : dat_wr
  task automatic check(input logic [7:0] mask, input int last);
    int n;
    repeat (320) @(posedge i_ref_clk);
    #1;
    for (int d = 0; d <= last; d++) begin
      n = 0;
      // wait for a blank gap so the digit is caught at the head of its slot
      while (dig !== 8'h00 && n < 400) begin
        @(posedge i_ref_clk);
        #1 n++;
      end
      while (dig !== exp_drive(d) && n < 800) begin
        @(posedge i_ref_clk);
        #1 n++;
      end
      repeat (3) @(posedge i_ref_clk);
      #1;
      `CHK(dig, exp_drive(d))
      `CHK(seg & mask, mem[d] & mask)
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
  initial begin
    i_rstn = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    seed = $urandom(65483);
    repeat (4) @(posedge i_ref_clk);
    #1;
    `CHK({dig, seg}, 16'h0000)
    i_rstn = 1'b1;
    ctl_wr(8'hB0);
    for (int i = 0; i <= DIGITS; i++) dat_wr(8'($urandom));
    check(8'hFF, 7);
    $display("test sequential done");
    // single digit at both address ends and one inside
    for (int k = 0; k < 3; k++) begin
      ctl_wr(8'h30 | (k == 0 ? 8'h00 : k == 1 ? 8'h07 : 8'($urandom_range(1, 6))));
      dat_wr(8'($urandom));
      dat_wr(8'($urandom));
      check(8'hFF, 7);
    end
    $display("test single done");
    // point bit in hex and code B lookup
    for (int j = 0; j < 2; j++) begin
      ctl_wr(j == 0 ? 8'h58 : 8'h18);
      v = {j == 0, 3'($urandom), 4'hA};
      dat_wr(v);
      // letter A in hex, dash in code B
      mem[0] = {v[7], (j == 0) ? 7'h77 : 7'h40};
      check(8'hFF, 0);
      mem[0] = v;
    end
    // bank B holds its own bytes, bank A untouched
    keep = mem;
    ctl_wr(8'h51);
    dat_wr(8'h05);
    mem[0] = 8'h3F;
    mem[1] = 8'h6D;
    check(8'hFF, 1);
    mem = keep;
    $display("test decode point done");
    ctl_wr(8'h20);
    for (int i = 0; i < 8; i++) begin
      repeat (50) @(posedge i_ref_clk);
      #1;
      `CHK({dig, seg}, 16'h0000)
    end
    ctl_wr(8'h30);
    check(8'hFF, 7);
    $display("test shutdown done");
    final_report();
  end
endmodule : led_display_host_write_port_bench
